//--- sdp_ram_pkg.sv
// constants and types shared by the simple dual-port ram and its storage array
package sdp_ram_pkg;

  // ***********************************************
  // array geometry
  // ***********************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int WORDS = 24;
  localparam int LANE_W = 8;
  localparam int MASK_W = DATA_W / LANE_W;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

  // ***********************************************
  // register map (byte addresses)
  // ***********************************************
  localparam logic [31:0] OFS_CFG = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;

  // ***********************************************
  // configuration register fields
  // ***********************************************
  localparam int CFG_W = 15;
  localparam int CFG_ARRAY = 0;
  localparam int CFG_RADDR_BYPASS = 1;
  localparam int CFG_Q_BYPASS = 2;
  localparam int CFG_EMULATE = 3;
  localparam int CFG_USE_REN = 4;
  localparam int CFG_USE_MASK = 5;
  localparam int CFG_MODE_LO = 6;
  localparam int CFG_CLR_DATA = 8;
  localparam int CFG_CLR_WADDR = 9;
  localparam int CFG_CLR_WEN = 10;
  localparam int CFG_CLR_RADDR = 11;
  localparam int CFG_CLR_REN = 12;
  localparam int CFG_CLR_Q = 13;
  localparam int CFG_CLR_MASK = 14;
  localparam logic [CFG_W-1:0] CFG_RESET = 15'h0000;

  // ***********************************************
  // status register fields
  // ***********************************************
  localparam int STAT_WADDR_LO = 0;
  localparam int STAT_RADDR_LO = 8;

  // ***********************************************
  // clocking arrangements
  // ***********************************************
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_RW = 2'h1,
    MODE_IO = 2'h2
  } clk_mode_t;

endpackage

//--- mem_port_if.sv
// connection between the port logic and the storage array
`timescale 1ns/1ns
interface mem_port_if;
  import sdp_ram_pkg::*;
  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [MASK_W-1:0] wmask;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output wmask, output raddr,
    input rdata);
  modport store (input we, input waddr, input wdata, input wmask, input raddr,
    output rdata);
endinterface

//--- ram_store.sv
// flip-flop storage array with per-lane write mask and combinational read
`timescale 1ns/1ns
module ram_store
  import sdp_ram_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // array access
  mem_port_if.store mp
);

  typedef struct packed {
    logic [WORDS-1:0][DATA_W-1:0] word;
  } store_t;

  store_t cur;
  store_t next_cur;
  logic [DATA_W-1:0] bit_mask;

  // ***********************************************
  // lane mask widened to bits
  // ***********************************************
  for (genvar l = 0; l < MASK_W; l++) begin : g_lane
    assign bit_mask[l*LANE_W +: LANE_W] = {LANE_W{mp.wmask[l]}};
  end

  always_comb begin
    next_cur = cur;
    // addresses past the last word are dropped, not aliased
    if (mp.we && (32'(mp.waddr) < WORDS)) begin
      next_cur.word[mp.waddr] = (cur.word[mp.waddr] & ~bit_mask) | (mp.wdata & bit_mask);
    end
  end

  assign mp.rdata = (32'(mp.raddr) < WORDS) ? cur.word[mp.raddr] : WORD_RESET;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule // ram_store

//--- sdp_ram.sv
// simple dual-port ram: one write port, one read port, configured over ahb-lite
`timescale 1ns/1ns

module sdp_ram
  import sdp_ram_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // clock edges of the two sides, as one-cycle pulses, with their clock enables and clear
  input wire logic in_tick,
  input wire logic in_fall,
  input wire logic out_tick,
  input wire logic in_clk_en,
  input wire logic out_clk_en,
  input wire logic clear,
  // write port
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic wr_en,
  input wire logic [MASK_W-1:0] wr_mask,
  input wire logic wr_addr_hold,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic rd_en,
  input wire logic rd_addr_hold,
  output logic [DATA_W-1:0] rd_data
);

  // ***********************************************
  // geometry checks
  // ***********************************************
  // lane and depth limits are fixed at elaboration; a bad build answers every transfer with error
  localparam bit LANE_OK = (LANE_W == 5 || LANE_W == 8 || LANE_W == 9 || LANE_W == 10) &&
    (MASK_W * LANE_W == DATA_W);
  localparam bit DEPTH_OK = (WORDS > (1 << (ADDR_W - 1))) && (WORDS <= (1 << ADDR_W)) &&
    (WORDS > 1);

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] waddr;
    logic wen;
    logic [MASK_W-1:0] wmask;
    logic [ADDR_W-1:0] raddr;
    logic ren;
    logic [DATA_W-1:0] q;
    logic cfg_wr_pend;
    logic [31:0] rdbuf;
  } state_t;

  state_t cur;
  state_t next_cur;
  mem_port_if mp ();

  logic is_array;
  logic raddr_bypass;
  logic q_bypass;
  logic emulate;
  logic use_ren;
  logic use_mask;
  clk_mode_t mode;
  logic in_en;
  logic out_en;
  logic raddr_en;
  logic q_en;
  logic [ADDR_W-1:0] waddr_eff;
  logic [ADDR_W-1:0] raddr_eff;
  logic ren_eff;
  logic [MASK_W-1:0] mask_eff;
  logic ahb_take;

  // ***********************************************
  // configuration decode
  // ***********************************************
  // options that the chosen build cannot offer are forced off here
  assign is_array = cur.cfg[CFG_ARRAY];
  assign raddr_bypass = is_array & cur.cfg[CFG_RADDR_BYPASS];
  assign q_bypass = cur.cfg[CFG_Q_BYPASS];
  assign emulate = ~is_array & cur.cfg[CFG_EMULATE];
  assign use_ren = ~is_array & cur.cfg[CFG_USE_REN];
  assign use_mask = is_array & cur.cfg[CFG_USE_MASK];
  assign mode = clk_mode_t'(cur.cfg[CFG_MODE_LO +: 2]);

  // ***********************************************
  // side clocks
  // ***********************************************
  assign in_en = in_tick & in_clk_en;
  always_comb begin
    if (mode == MODE_RW) begin
      raddr_en = out_tick & out_clk_en;
      q_en = out_tick & out_clk_en;
    end else if (mode == MODE_IO) begin
      raddr_en = in_en;
      q_en = out_tick & out_clk_en;
    end else begin
      raddr_en = in_en;
      q_en = in_en;
    end
  end
  assign out_en = q_en;

  // ***********************************************
  // write path
  // ***********************************************
  assign waddr_eff = wr_addr_hold ? cur.waddr : wr_addr;
  assign mask_eff = use_mask ? wr_mask : {MASK_W{1'b1}};

  always_comb begin
    if (emulate) begin
      // falling-edge build writes what the rising edge captured
      mp.we = in_fall & in_clk_en & cur.wen;
      mp.waddr = cur.waddr;
      mp.wdata = cur.wdata;
      mp.wmask = cur.wmask;
    end else begin
      mp.we = in_en & wr_en;
      mp.waddr = waddr_eff;
      mp.wdata = wr_data;
      mp.wmask = mask_eff;
    end
  end

  // ***********************************************
  // read path
  // ***********************************************
  // without raddr_bypass the registered address feeds the array, so a new address reaches q one edge later
  assign raddr_eff = raddr_bypass ? rd_addr : cur.raddr;
  assign ren_eff = ~use_ren | (raddr_bypass ? rd_en : cur.ren);
  assign mp.raddr = raddr_eff;
  assign rd_data = q_bypass ? mp.rdata : cur.q;

  ram_store u_store (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .mp(mp.store)
  );

  // ***********************************************
  // bus slave
  // ***********************************************
  // zero wait states: read data is fetched during the address phase
  assign ahb_take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = ~(LANE_OK & DEPTH_OK);
  assign hrdata = cur.rdbuf;

  always_comb begin
    next_cur = cur;
    // configuration write lands in its data phase
    if (cur.cfg_wr_pend) begin
      next_cur.cfg = hwdata[CFG_W-1:0];
    end
    next_cur.cfg_wr_pend = 1'b0;
    if (ahb_take) begin
      if (hwrite) begin
        next_cur.cfg_wr_pend = (haddr == OFS_CFG);
      end else if (haddr == OFS_CFG) begin
        // forwarding keeps a read right after a write coherent
        next_cur.rdbuf = 32'(next_cur.cfg);
      end else if (haddr == OFS_STATUS) begin
        next_cur.rdbuf = '0;
        next_cur.rdbuf[STAT_WADDR_LO +: ADDR_W] = cur.waddr;
        next_cur.rdbuf[STAT_RADDR_LO +: ADDR_W] = cur.raddr;
      end else begin
        next_cur.rdbuf = '0;
      end
    end

    // write-side input registers
    if (in_en) begin
      next_cur.wdata = wr_data;
      next_cur.waddr = waddr_eff;
      next_cur.wen = wr_en;
      next_cur.wmask = mask_eff;
    end
    // read address and strobe registers
    if (raddr_en) begin
      if (!rd_addr_hold || raddr_bypass) begin
        next_cur.raddr = rd_addr;
      end
      next_cur.ren = rd_en;
    end
    // read data register
    if (out_en && ren_eff) begin
      next_cur.q = mp.rdata;
    end

    // clear wins over a capture on the same cycle in each register whose clear bit is set in cfg
    if (clear) begin
      if (cur.cfg[CFG_CLR_DATA]) begin
        next_cur.wdata = '0;
      end
      if (cur.cfg[CFG_CLR_WADDR]) begin
        next_cur.waddr = '0;
      end
      if (cur.cfg[CFG_CLR_WEN]) begin
        next_cur.wen = 1'b0;
      end
      if (cur.cfg[CFG_CLR_MASK]) begin
        next_cur.wmask = '0;
      end
      if (cur.cfg[CFG_CLR_RADDR]) begin
        next_cur.raddr = '0;
      end
      if (cur.cfg[CFG_CLR_REN]) begin
        next_cur.ren = 1'b0;
      end
      if (cur.cfg[CFG_CLR_Q]) begin
        next_cur.q = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.cfg <= CFG_RESET;
    end else begin
      cur <= next_cur;
    end
  end

endmodule // sdp_ram

//--- side_ticks.sv
// far-side model: side clock edges of the ram as pulses on the system clock
`timescale 1ns/1ns
module side_ticks #(
  parameter int IN_DIV = 4,
  parameter int OUT_DIV = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // arrangement
  input wire logic single,
  // side clock edges
  output logic in_tick,
  output logic in_fall,
  output logic out_tick
);
  // unequal periods so the two sides drift against each other
  int ci;
  int co;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ci <= 0;
      co <= 0;
    end else begin
      ci <= (ci + 1) % IN_DIV;
      co <= (co + 1) % OUT_DIV;
    end
  end
  assign in_tick = (ci == 0);
  assign in_fall = (ci == IN_DIV / 2);
  assign out_tick = single ? in_tick : (co == 0);
endmodule // side_ticks

//--- sdp_ram_chk.sv
// port assertions for the simple dual-port ram
`timescale 1ns/1ns
module sdp_ram_chk
  import sdp_ram_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // ram ports
  input wire logic in_tick,
  input wire logic out_tick,
  input wire logic in_clk_en,
  input wire logic out_clk_en,
  input wire logic clear,
  input wire logic [DATA_W-1:0] rd_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic rd_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  AST_READY: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_UNMAPPED: assert property (rd_take && haddr > OFS_STATUS |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_HRDATA_HOLD: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_CFG_TOP: assert property (rd_take && haddr == OFS_CFG |=> hrdata[31:15] == 17'h00000)
    else $error("unused config bits set");
  AST_NO_TICK: assert property (!in_tick && !out_tick && !clear |=> $stable(rd_data))
    else $error("read data moved without a tick");
  AST_GATED: assert property (!in_clk_en && !out_clk_en && !clear |=> $stable(rd_data))
    else $error("read data moved while gated");
  AST_WAKE: assert property ($rose(nrst) |-> rd_data == 16'h0000 && hrdata == 32'h0000_0000)
    else $error("outputs not zero after reset");
  cover property (rd_take && haddr == OFS_CFG);
  cover property (out_tick && !in_tick);
  cover property (clear ##1 rd_data == 16'h0000);
endmodule // sdp_ram_chk

bind sdp_ram sdp_ram_chk u_sdp_ram_chk (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .in_tick, .out_tick, .in_clk_en, .out_clk_en, .clear,
  .rd_data);

//--- tb.sv
// self-checking bench for the simple dual-port ram
`timescale 1ns/1ns
module tb;
  import sdp_ram_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, single = 1'b1;
  logic in_clk_en = 1'b1, out_clk_en = 1'b1, clear = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic wr_addr_hold = 1'b0, rd_addr_hold = 1'b0, hreadyout, hresp, in_tick, in_fall, out_tick;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic [DATA_W-1:0] wr_data = 16'h0000, rd_data, v;
  logic [ADDR_W-1:0] wr_addr = 5'h00, rd_addr = 5'h00;
  logic [MASK_W-1:0] wr_mask = 2'h3;
  int fails = 0, samples_checked = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  sdp_ram u_sdp_ram (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .in_tick, .in_fall, .out_tick,
    .in_clk_en, .out_clk_en, .clear, .wr_data, .wr_addr, .wr_en, .wr_mask, .wr_addr_hold,
    .rd_addr, .rd_en, .rd_addr_hold, .rd_data);
  side_ticks u_side_ticks (.clk_sys, .nrst, .single, .in_tick, .in_fall, .out_tick);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // waits for an edge of the chosen side, seen as the design samples it
  task automatic step(input logic o);
    do @(posedge clk_sys); while ((o ? out_tick : in_tick) !== 1'b1);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] m,
    input logic e);
    wr_addr <= a;
    wr_data <= d;
    wr_mask <= m;
    wr_en <= e;
    step(1'b0);
    wr_en <= 1'b0;
  endtask
  // one in edge then two out edges suits every clocking arrangement
  task automatic rd(input logic [4:0] a);
    rd_addr <= a;
    step(1'b0);
    step(1'b1);
    step(1'b1);
    @(posedge clk_sys);
    v = rd_data;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    check(q[15:0], 16'h0000);
    rd(5'h05);
    check(v, 16'h0000);
    wr(5'h03, 16'hA5C3, 2'h3, 1'b1);
    rd(5'h03);
    check(v, 16'hA5C3);
    wr(5'h03, 16'h0F0F, 2'h3, 1'b0);
    rd(5'h03);
    check(v, 16'hA5C3);
    wr_addr_hold <= 1'b1;
    wr(5'h07, 16'h1234, 2'h3, 1'b1);
    rd(5'h07);
    check(v, 16'h0000);
    rd_addr_hold <= 1'b1;
    rd(5'h03);
    check(v, 16'h0000);
    rd_addr_hold <= 1'b0;
    wr_addr_hold <= 1'b0;
    rd(5'h03);
    check(v, 16'h1234);
    in_clk_en <= 1'b0;
    out_clk_en <= 1'b0;
    wr(5'h09, 16'hBEEF, 2'h3, 1'b1);
    in_clk_en <= 1'b1;
    out_clk_en <= 1'b1;
    rd(5'h09);
    check(v, 16'h0000);
    bus(1'b1, OFS_CFG, 32'h0000_0010);
    rd(5'h03);
    check(v, 16'h0000);
    rd_en <= 1'b1;
    rd(5'h03);
    check(v, 16'h1234);
    bus(1'b1, OFS_CFG, 32'h0000_0008);
    wr(5'h0D, 16'h0F0F, 2'h3, 1'b1);
    rd(5'h0D);
    check(v, 16'h0F0F);
    bus(1'b1, OFS_CFG, 32'h0000_0021);
    wr(5'h03, 16'hFFFF, 2'h1, 1'b1);
    rd(5'h03);
    check(v, 16'h12FF);
    bus(1'b1, OFS_CFG, 32'h0000_0061);
    single <= 1'b0;
    wr(5'h0B, 16'h5A5A, 2'h3, 1'b1);
    rd(5'h0B);
    check(v, 16'h5A5A);
    bus(1'b1, OFS_CFG, 32'h0000_00A1);
    rd(5'h03);
    check(v, 16'h12FF);
    bus(1'b0, OFS_CFG, 32'h0000_0000);
    check(q[15:0], 16'h00A1);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check(q[15:0], 16'h030B);
    bus(1'b1, OFS_CFG, 32'h0000_0003);
    rd_addr_hold <= 1'b1;
    rd(5'h0B);
    check(v, 16'h5A5A);
    rd_addr_hold <= 1'b0;
    bus(1'b1, OFS_CFG, 32'h0000_20A1);
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
    @(posedge clk_sys);
    check(rd_data, 16'h0000);
    give_verdict();
  end
endmodule // tb
